/* design/flip_arbiter.sv */
// Picks the highest-level enabled request, polling order among equals
`timescale 1ns/100ps
module flip_arbiter
   import flip_pkg::*;
(
   // Requests and levels
   input wire flip_src_t req,
   input wire logic [13:0] levels,
   // Winner
   output logic found,
   output logic [2:0] win_idx,
   output flip_level_t win_level
);
   always_comb begin
      found = 1'b0;
      win_idx = 3'h0;
      win_level = 2'h0;
      // R12 fixed polling order
      for (int i = 0; i < 7; i++) begin
         if (req[i] && (!found || levels[2*i +: 2] > win_level)) begin
            found = 1'b1;
            win_idx = 3'(i);
            win_level = levels[2*i +: 2];
         end
      end
   end
endmodule : flip_arbiter

/* design/flip_controller.sv */
// Four-level nested interrupt controller with APB register access
//
// The APB interface to the registers is this design's own decision.
`include "flip_regs.svh"
`timescale 1ns/100ps
// Notes on behaviour
// R1: Seven sources, each at one of four levels, when counter array present.
// R2: Without counter array only six sources; its enable and priority bits absent.
// R3: Control held in enable, low priority and high priority registers.
// R4: High priority register decoded at special register address B7H; decoded here at APB offset 2DCH.
// R5: Level is high bit then low bit; 11 highest, 00 lowest.
// R6: Four nesting levels, otherwise classic servicing scheme.
// R7: Serve pending enabled request when no equal or higher level active.
// R8: Equal or higher level active: request waits until handler finishes.
// R9: Higher request pre-empts running lower-level handler at once.
// R10: Pre-empted handler resumes on completion; in-service tracked per level.
// R11: External flag cleared on vectoring only when transition activated.
// R12: Same-level ties polled ext0, t0, ext1, t1, counter array, serial, t2.
// R13: Needs own and global enable; timer0/1 and edge external flags auto-clear.
module flip_controller
   import flip_pkg::*;
#(
   parameter bit HAS_COUNTER_ARRAY = 1'b1
)
(
   // APB
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // External requests, timers, counter array, serial
   input wire logic ext0_pin_event,
   input wire logic ext1_pin_event,
   input wire logic timer0_overflow_flag,
   input wire logic timer1_overflow_flag,
   input wire logic counter_array_overflow_flag,
   input wire logic [4:0] module_match_capture_flag,
   input wire logic serial_receive_flag,
   input wire logic serial_transmit_flag,
   input wire logic timer2_overflow_flag,
   input wire logic timer2_external_flag,
   // Core sequencer
   input wire logic vector_ack,
   input wire logic handler_return,
   output logic irq_request,
   output flip_vec_t irq_vector,
   output logic timer0_flag_clear,
   output logic timer1_flag_clear,
   // Request flags
   output logic ext0_request_flag,
   output logic ext1_request_flag
);
   logic [7:0] interrupt_enable;
   logic [7:0] interrupt_priority_high;
   logic [7:0] interrupt_priority_low;
   logic [1:0] ext_transition_mode;
   logic [6:0] impl_mask;
   flip_src_t raw_req;
   flip_src_t req;
   logic [13:0] levels;
   logic found;
   logic [2:0] win_idx;
   flip_level_t win_level;
   logic [3:0] in_service;
   logic allowed;
   logic taken;
   logic [2:0] taken_idx;
   flip_level_t taken_level;
   flip_state_e state;
   logic wr_en;
   logic rd_en;
   logic addr_ok;
   logic ext0_clear;
   logic ext1_clear;
   flip_src_t enable_poll;
   flip_src_t prio_high_poll;
   flip_src_t prio_low_poll;

   // Register bits run ext0,t0,ext1,t1,serial,t2,counter array; arbiter wants polling order
   function automatic flip_src_t flip_to_poll(input logic [6:0] bits);
      flip_to_poll = {bits[5], bits[4], bits[6], bits[3:0]};
   endfunction : flip_to_poll

   // R1 seven sources, R2 drop counter array
   // Mask is in register bit order, counter array at bit 6
   assign impl_mask = HAS_COUNTER_ARRAY ? 7'h7F : 7'h3F;

   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && !pwrite;
   assign pready = 1'b1;

   // R3 three registers, R4 high priority at APB offset 2DCH rather than B7H
   always_comb begin
      case (paddr)
         `FLIP_OFF_ENABLE: addr_ok = 1'b1;
         `FLIP_OFF_PRIO_HIGH: addr_ok = 1'b1;
         `FLIP_OFF_PRIO_LOW: addr_ok = 1'b1;
         `FLIP_OFF_CONTROL: addr_ok = 1'b1;
         `FLIP_OFF_STATUS: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end
   assign pslverr = psel && penable && !addr_ok;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         interrupt_enable <= `FLIP_RST_ENABLE;
      end else if (wr_en && paddr == `FLIP_OFF_ENABLE) begin
         // R2 absent enable bit stays zero
         interrupt_enable <= pwdata[7:0] & {1'b1, impl_mask};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         interrupt_priority_high <= `FLIP_RST_PRIO;
         interrupt_priority_low <= `FLIP_RST_PRIO;
      end else if (wr_en) begin
         if (paddr == `FLIP_OFF_PRIO_HIGH) begin
            interrupt_priority_high <= pwdata[7:0] & {1'b0, impl_mask};
         end
         if (paddr == `FLIP_OFF_PRIO_LOW) begin
            interrupt_priority_low <= pwdata[7:0] & {1'b0, impl_mask};
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_transition_mode <= `FLIP_RST_CONTROL;
      end else if (wr_en && paddr == `FLIP_OFF_CONTROL) begin
         ext_transition_mode <= pwdata[1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd_en && !penable) begin
         case (paddr)
            `FLIP_OFF_ENABLE: prdata <= {24'h00_0000, interrupt_enable};
            `FLIP_OFF_PRIO_HIGH: prdata <= {24'h00_0000, interrupt_priority_high};
            `FLIP_OFF_PRIO_LOW: prdata <= {24'h00_0000, interrupt_priority_low};
            `FLIP_OFF_CONTROL: prdata <= {30'h0000_0000, ext_transition_mode};
            `FLIP_OFF_STATUS: prdata <= {16'h0000, 1'b0, taken_idx, in_service,
                                         1'b0, req};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   // External flags: level mode follows pin, transition mode is sticky
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext0_request_flag <= 1'b0;
         ext1_request_flag <= 1'b0;
      end else begin
         // R11 clear on vector only when transition activated; set wins
         if (!ext_transition_mode[0]) ext0_request_flag <= ext0_pin_event;
         else if (ext0_pin_event) ext0_request_flag <= 1'b1;
         else if (ext0_clear) ext0_request_flag <= 1'b0;
         if (!ext_transition_mode[1]) ext1_request_flag <= ext1_pin_event;
         else if (ext1_pin_event) ext1_request_flag <= 1'b1;
         else if (ext1_clear) ext1_request_flag <= 1'b0;
      end
   end

   assign raw_req = {timer2_overflow_flag | timer2_external_flag,
                     serial_receive_flag | serial_transmit_flag,
                     counter_array_overflow_flag | (|module_match_capture_flag),
                     timer1_overflow_flag, ext1_request_flag,
                     timer0_overflow_flag, ext0_request_flag};

   assign enable_poll = flip_to_poll(interrupt_enable[6:0] & impl_mask);
   assign prio_high_poll = flip_to_poll(interrupt_priority_high[6:0]);
   assign prio_low_poll = flip_to_poll(interrupt_priority_low[6:0]);

   // R13 own and global enable
   assign req = raw_req & enable_poll & {7{interrupt_enable[`FLIP_BIT_GLOBAL]}};

   // R5 level = {high, low}
   always_comb begin
      levels = 14'h0000;
      for (int i = 0; i < 7; i++) begin
         levels[2*i +: 2] = {prio_high_poll[i], prio_low_poll[i]};
      end
   end

   flip_arbiter u_arbiter (
      .req(req),
      .levels(levels),
      .found(found),
      .win_idx(win_idx),
      .win_level(win_level)
   );

   // R6 R7 R8 R9 no equal or higher level in service
   assign allowed = found && ((in_service >> win_level) == 4'h0);

   // Vector offered until core acknowledges; winner frozen meanwhile
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= FLIP_IDLE;
         taken_idx <= 3'h0;
         taken_level <= 2'h0;
         irq_vector <= 8'h00;
      end else begin
         case (state)
            FLIP_IDLE: begin
               if (allowed && !handler_return) begin
                  state <= FLIP_VECTOR;
                  taken_idx <= win_idx;
                  taken_level <= win_level;
                  irq_vector <= flip_vector(win_idx);
               end
            end
            FLIP_VECTOR: begin
               if (vector_ack) state <= FLIP_IDLE;
            end
            default: state <= FLIP_IDLE;
         endcase
      end
   end

   assign irq_request = (state == FLIP_VECTOR);
   assign taken = irq_request && vector_ack;
   // R13 auto-clear strobes for timers 0/1 and external flags
   assign timer0_flag_clear = taken && taken_idx == 3'h1;
   assign timer1_flag_clear = taken && taken_idx == 3'h3;
   assign ext0_clear = taken && taken_idx == 3'h0;
   assign ext1_clear = taken && taken_idx == 3'h2;

   flip_service_stack u_stack (
      .pclk(pclk),
      .presetn(presetn),
      .enter(taken),
      .enter_level(taken_level),
      .leave(handler_return),
      .in_service(in_service)
   );
endmodule : flip_controller

/* design/flip_pkg.sv */
// Types shared by the interrupt priority block
package flip_pkg;
   typedef logic [1:0] flip_level_t;
   typedef logic [6:0] flip_src_t;
   typedef logic [7:0] flip_vec_t;
   typedef enum logic [1:0] {
      FLIP_IDLE,
      FLIP_VECTOR
   } flip_state_e;
   function automatic flip_vec_t flip_vector(input logic [2:0] idx);
      case (idx)
         3'h0: flip_vector = 8'h03;
         3'h1: flip_vector = 8'h0B;
         3'h2: flip_vector = 8'h13;
         3'h3: flip_vector = 8'h1B;
         3'h4: flip_vector = 8'h33;
         3'h5: flip_vector = 8'h23;
         default: flip_vector = 8'h2B;
      endcase
   endfunction : flip_vector
endpackage : flip_pkg

/* design/flip_regs.svh */
// Register offsets, field positions and reset values of the interrupt priority block
`ifndef FLIP_REGS_SVH
`define FLIP_REGS_SVH
`define FLIP_OFF_ENABLE 12'h2A0
`define FLIP_OFF_PRIO_HIGH 12'h2DC
`define FLIP_OFF_PRIO_LOW 12'h2E0
`define FLIP_OFF_CONTROL 12'h300
`define FLIP_OFF_STATUS 12'h304
`define FLIP_IDX_ENABLE 8'hA8
`define FLIP_IDX_PRIO_HIGH 8'hB7
`define FLIP_IDX_PRIO_LOW 8'hB8
`define FLIP_BIT_GLOBAL 7
`define FLIP_BIT_COUNTER_ARRAY 6
`define FLIP_RST_ENABLE 8'h00
`define FLIP_RST_PRIO 8'h00
`define FLIP_RST_CONTROL 2'h0
`define FLIP_NUM_SRC 7
`endif

/* design/flip_service_stack.sv */
// Per-level in-service bits; return clears the highest active level
`timescale 1ns/100ps
module flip_service_stack
   import flip_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control
   input wire logic enter,
   input wire flip_level_t enter_level,
   input wire logic leave,
   // State
   output logic [3:0] in_service
);
   logic [3:0] top_mask;
   always_comb begin
      top_mask = 4'h0;
      if (in_service[3]) top_mask = 4'h8;
      else if (in_service[2]) top_mask = 4'h4;
      else if (in_service[1]) top_mask = 4'h2;
      else if (in_service[0]) top_mask = 4'h1;
   end
   // R10 per-level tracking, resume lower
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_service <= 4'h0;
      end else begin
         in_service <= (in_service & ~(leave ? top_mask : 4'h0))
                       | (enter ? (4'h1 << enter_level) : 4'h0);
      end
   end
endmodule : flip_service_stack

/* tb/flip_controller_tb.sv */
// Self-checking bench for the four-level interrupt controller
`timescale 1ns/100ps
`include "flip_regs.svh"
module flip_controller_tb;
   import flip_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ret_cmd;
   logic irq_request, vector_ack, handler_return, t0_clr, t1_clr, ext0_flag, ext1_flag;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, prdata_six;
   logic irq_six;
   logic [6:0] src;
   logic [7:0] taken_cnt;
   logic [3:0] ack_delay;
   flip_vec_t irq_vector, taken_vec;
   int err_count = 0;
   int tests_run = 0;
   int cycles = 0;
   flip_controller #(.HAS_COUNTER_ARRAY(1'b1)) dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext0_pin_event(src[0]),
      .ext1_pin_event(src[2]), .timer0_overflow_flag(src[1]), .timer1_overflow_flag(src[3]),
      .counter_array_overflow_flag(src[4]), .module_match_capture_flag(5'h00),
      .serial_receive_flag(src[5]), .serial_transmit_flag(1'b0),
      .timer2_overflow_flag(src[6]), .timer2_external_flag(1'b0), .vector_ack(vector_ack),
      .handler_return(handler_return), .irq_request(irq_request), .irq_vector(irq_vector),
      .timer0_flag_clear(t0_clr), .timer1_flag_clear(t1_clr),
      .ext0_request_flag(ext0_flag), .ext1_request_flag(ext1_flag));
   // Six-source variant shares the bus; its counter array request is held high
   flip_controller #(.HAS_COUNTER_ARRAY(1'b0)) dut_six (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata_six), .pready(), .pslverr(), .ext0_pin_event(1'b0),
      .ext1_pin_event(1'b0), .timer0_overflow_flag(1'b0), .timer1_overflow_flag(1'b0),
      .counter_array_overflow_flag(1'b1), .module_match_capture_flag(5'h1F),
      .serial_receive_flag(1'b0), .serial_transmit_flag(1'b0),
      .timer2_overflow_flag(1'b0), .timer2_external_flag(1'b0), .vector_ack(1'b0),
      .handler_return(1'b0), .irq_request(irq_six), .irq_vector(),
      .timer0_flag_clear(), .timer1_flag_clear(), .ext0_request_flag(),
      .ext1_request_flag());
   flip_core_model core (.pclk(pclk), .presetn(presetn), .irq_request(irq_request),
      .irq_vector(irq_vector), .vector_ack(vector_ack), .handler_return(handler_return),
      .ack_delay(ack_delay), .ret_cmd(ret_cmd), .taken_vec(taken_vec), .taken_cnt(taken_cnt));
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
      input logic [31:0] exp, input logic err);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      if (!wr) chk(prdata, exp);
      chk({31'h0, pslverr}, {31'h0, err});
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic none(input int n);
      logic [7:0] c;
      c = taken_cnt;
      repeat (n) @(posedge pclk);
      chk({24'h0, taken_cnt}, {24'h0, c});
   endtask : none
   // Source is dropped after take, as its peripheral or software would
   task automatic wait_take(input flip_vec_t v, input int k);
      logic [7:0] c;
      c = taken_cnt;
      while (taken_cnt === c) @(posedge pclk);
      chk({24'h0, taken_vec}, {24'h0, v});
      src[k] <= 1'b0;
   endtask : wait_take
   task automatic ret();
      ret_cmd <= 1'b1;
      @(posedge pclk);
      ret_cmd <= 1'b0;
      repeat (2) @(posedge pclk);
   endtask : ret
   task automatic s_regs();
      apb(1'b1, `FLIP_OFF_ENABLE, 32'h55, 32'h0, 1'b0);
      apb(1'b0, `FLIP_OFF_ENABLE, 32'h0, 32'h55, 1'b0);
      chk(prdata_six, 32'h15);
      apb(1'b1, `FLIP_OFF_PRIO_HIGH, 32'hFF, 32'h0, 1'b0);
      apb(1'b0, `FLIP_OFF_PRIO_HIGH, 32'h0, 32'h7F, 1'b0);
      chk(prdata_six, 32'h3F);
      apb(1'b1, `FLIP_OFF_PRIO_LOW, 32'hFF, 32'h0, 1'b0);
      apb(1'b0, `FLIP_OFF_PRIO_LOW, 32'h0, 32'h7F, 1'b0);
      apb(1'b0, 12'h010, 32'h0, 32'h0, 1'b1);
      apb(1'b1, `FLIP_OFF_ENABLE, 32'h7F, 32'h0, 1'b0);
      src <= 7'h02;
      none(8);
      src <= 7'h00;
   endtask : s_regs
   task automatic s_poll();
      flip_vec_t vec [7] = '{8'h03, 8'h0B, 8'h13, 8'h1B, 8'h33, 8'h23, 8'h2B};
      apb(1'b1, `FLIP_OFF_PRIO_HIGH, 32'h0, 32'h0, 1'b0);
      apb(1'b1, `FLIP_OFF_PRIO_LOW, 32'h0, 32'h0, 1'b0);
      // Global enable last, so registered external flags are up before arbitration
      src <= 7'h7F;
      apb(1'b1, `FLIP_OFF_ENABLE, 32'hFF, 32'h0, 1'b0);
      for (int k = 0; k < 7; k++) begin
         wait_take(vec[k], k);
         if (k == 0) chk({31'h0, ext0_flag}, 32'h1);
         none(5);
         ret();
      end
      chk({31'h0, irq_six}, 32'h0);
   endtask : s_poll
   task automatic s_nest();
      ack_delay <= 4'h3;
      apb(1'b1, `FLIP_OFF_PRIO_HIGH, 32'h0C, 32'h0, 1'b0);
      apb(1'b1, `FLIP_OFF_PRIO_LOW, 32'h18, 32'h0, 1'b0);
      src <= 7'h20;
      wait_take(8'h23, 5);
      src[3] <= 1'b1;
      wait_take(8'h1B, 3);
      src[2] <= 1'b1;
      none(10);
      ret();
      wait_take(8'h13, 2);
      repeat (2) @(posedge pclk);
      apb(1'b0, `FLIP_OFF_STATUS, 32'h0, 32'h2600, 1'b0);
      ret();
      apb(1'b0, `FLIP_OFF_STATUS, 32'h0, 32'h2200, 1'b0);
      ret();
   endtask : s_nest
   task automatic s_edge();
      apb(1'b1, `FLIP_OFF_CONTROL, 32'h3, 32'h0, 1'b0);
      src <= 7'h05;
      @(posedge pclk);
      src <= 7'h00;
      repeat (2) @(posedge pclk);
      chk({31'h0, ext0_flag}, 32'h1);
      chk({31'h0, ext1_flag}, 32'h1);
      // Ext1 still sits at level 2 from the nesting scenario, so it goes first
      wait_take(8'h13, 2);
      chk({31'h0, ext1_flag}, 32'h0);
      chk({31'h0, ext0_flag}, 32'h1);
      ret();
      wait_take(8'h03, 0);
      chk({31'h0, ext0_flag}, 32'h0);
      ret();
   endtask : s_edge
   task automatic finish_test();
      if (err_count == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : finish_test
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         err_count++;
         finish_test();
      end
   end
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      src = 7'h00;
      ret_cmd = 1'b0;
      ack_delay = 4'h0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      s_regs();
      s_poll();
      s_nest();
      s_edge();
      finish_test();
   end
endmodule : flip_controller_tb
bind flip_controller flip_properties chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
   .irq_request(irq_request), .irq_vector(irq_vector), .vector_ack(vector_ack),
   .handler_return(handler_return), .timer0_flag_clear(timer0_flag_clear),
   .timer1_flag_clear(timer1_flag_clear));

/* tb/flip_core_model.sv */
// Core sequencer model: takes offered vectors, returns from handlers
`timescale 1ns/100ps
module flip_core_model
   import flip_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Controller side
   input wire logic irq_request,
   input wire flip_vec_t irq_vector,
   output logic vector_ack,
   output logic handler_return,
   // Bench control and record
   input wire logic [3:0] ack_delay,
   input wire logic ret_cmd,
   output flip_vec_t taken_vec,
   output logic [7:0] taken_cnt
);
   logic [3:0] wait_cnt;
   // Slow core acks only after ack_delay cycles of offer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vector_ack <= 1'b0;
         wait_cnt <= 4'h0;
         taken_vec <= 8'h00;
         taken_cnt <= 8'h00;
      end else if (vector_ack) begin
         vector_ack <= 1'b0;
         wait_cnt <= 4'h0;
         taken_vec <= irq_vector;
         taken_cnt <= taken_cnt + 8'h01;
      end else if (irq_request && wait_cnt >= ack_delay) begin
         vector_ack <= 1'b1;
      end else if (irq_request) begin
         wait_cnt <= wait_cnt + 4'h1;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         handler_return <= 1'b0;
      end else begin
         handler_return <= ret_cmd;
      end
   end
endmodule : flip_core_model

/* tb/flip_properties.sv */
// Port checker for the interrupt priority block
`timescale 1ns/100ps
`include "flip_regs.svh"
module flip_properties
   import flip_pkg::*;
(
   // Clock, reset and bus
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [11:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   // Core side
   input wire logic irq_request,
   input wire flip_vec_t irq_vector,
   input wire logic vector_ack,
   input wire logic handler_return,
   input wire logic timer0_flag_clear,
   input wire logic timer1_flag_clear
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic acc;
   assign acc = psel && penable;
   chk_zero_wait: assert property (acc |-> pready)
      else $error("pready low in access phase");
   chk_unmapped_err: assert property (acc && !(paddr inside {`FLIP_OFF_ENABLE,
      `FLIP_OFF_PRIO_HIGH, `FLIP_OFF_PRIO_LOW, `FLIP_OFF_CONTROL, `FLIP_OFF_STATUS}) |-> pslverr)
      else $error("unmapped access without error");
   chk_prio_high_ok: assert property (acc && paddr == `FLIP_OFF_PRIO_HIGH |-> !pslverr)
      else $error("priority high access refused");
   chk_offer_holds: assert property (irq_request && !vector_ack |=> irq_request && $stable(irq_vector))
      else $error("offer dropped or changed before ack");
   chk_offer_ends: assert property (irq_request && vector_ack |=> !irq_request)
      else $error("offer kept after ack");
   chk_no_offer_return: assert property (!irq_request && handler_return |=> !irq_request)
      else $error("offer raised on handler return");
   chk_vector_legal: assert property (irq_request |-> irq_vector inside {8'h03, 8'h0B, 8'h13,
      8'h1B, 8'h33, 8'h23, 8'h2B})
      else $error("illegal vector offered");
   chk_t0_clear_cause: assert property (timer0_flag_clear |-> irq_request && vector_ack && irq_vector == 8'h0B)
      else $error("timer0 clear without its ack");
   chk_t1_clear_cause: assert property (timer1_flag_clear |-> irq_request && vector_ack && irq_vector == 8'h1B)
      else $error("timer1 clear without its ack");
   chk_t0_clear_given: assert property (irq_request && vector_ack && irq_vector == 8'h0B |-> timer0_flag_clear)
      else $error("timer0 ack without clear");
endmodule : flip_properties
